/* rtl/sysdec_pkg.sv */
// Constants, encodings and types shared by the system instruction decoder.
// Functional notes
// - Cache invalidate translates and checks before acting
// - Present instruction cache block becomes invalid
// - Data cache contents and state untouched
// - Invalidate broadcast on system bus unless translation faults
// - Misaligned external word: inhibited, maybe split
// - Register number rebuilt from swapped halves
// - High half bits 16-20, low 11-15
// - Map monitor, counter and sample registers
// - Map implementation, breakpoint, bus, cache, id
// - System call raises exception at user level
// - Both interrupt returns are supervisor resume
// - Machine state moves: word, double, read
// - Supervisor register numbers reachable when privileged
package sysdec_pkg;

	// ======================================================
	// Instruction word fields (bit 0 is the MSB of the word)
	// ======================================================
	localparam int INSTR_W = 32;
	localparam int PRIMARY_HI = 31;
	localparam int PRIMARY_LO = 26;
	localparam int XO_HI = 10;
	localparam int XO_LO = 1;
	localparam int SPR_HALF_A_HI = 15; // Instruction bits 16-20
	localparam int SPR_HALF_A_LO = 11;
	localparam int SPR_HALF_B_HI = 20; // Instruction bits 11-15
	localparam int SPR_HALF_B_LO = 16;
	localparam int SPR_W = 10;
	localparam int SPR_PRIV_BIT = 9; // Number MSB marks a supervisor register

	// ======================================================
	// Opcode encodings
	// ======================================================
	localparam logic [5:0] OP_SYSCALL = 6'h11;
	localparam logic [5:0] OP_BRANCH_EXT = 6'h13;
	localparam logic [5:0] OP_INT_EXT = 6'h1F;
	localparam logic [9:0] XO_RFI = 10'h032;
	localparam logic [9:0] XO_RFID = 10'h012;
	localparam logic [9:0] XO_ICACHE_INVAL = 10'h3D6;
	localparam logic [9:0] XO_EXT_IN = 10'h136;
	localparam logic [9:0] XO_EXT_OUT = 10'h1B6;
	localparam logic [9:0] XO_MSR_TO = 10'h092;
	localparam logic [9:0] XO_MSR_TO_D = 10'h0B2;
	localparam logic [9:0] XO_MSR_FROM = 10'h053;
	localparam logic [9:0] XO_SPR_TO = 10'h1D3;
	localparam logic [9:0] XO_SPR_FROM = 10'h153;

	// ======================================================
	// Implementation register numbers
	// ======================================================
	localparam logic [9:0] SPR_MON_CTRL_0 = 10'h31B; // 795
	localparam logic [9:0] SPR_MON_CTRL_1 = 10'h31E; // 798
	localparam logic [9:0] SPR_PERF_FIRST = 10'h313; // 787
	localparam logic [9:0] SPR_PERF_LAST = 10'h31A; // 794
	localparam logic [9:0] SPR_SAMPLED_IA = 10'h30C; // Halves 11000 and 01100
	localparam logic [9:0] SPR_SAMPLED_DA = 10'h30D; // 781
	localparam logic [9:0] SPR_HW_IMPL_0 = 10'h3F0; // 1008
	localparam logic [9:0] SPR_IBRK = 10'h3F2; // 1010
	localparam logic [9:0] SPR_BUS_CS = 10'h3F8; // 1016
	localparam logic [9:0] SPR_L2_CTRL = 10'h3F9; // 1017
	localparam logic [9:0] SPR_L2_STAT = 10'h3FA; // 1018
	localparam logic [9:0] SPR_PROC_ID = 10'h3FF; // 1023

	// Word alignment mask for external control accesses
	localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;

	// Register selected by a move to or from a special register
	typedef enum logic [3:0] {
		SPR_ARCH,
		SPR_ID_MON_CTRL_0,
		SPR_ID_MON_CTRL_1,
		SPR_ID_PERF,
		SPR_ID_SAMPLED_IA,
		SPR_ID_SAMPLED_DA,
		SPR_ID_HW_IMPL_0,
		SPR_ID_IBRK,
		SPR_ID_BUS_CS,
		SPR_ID_L2_CTRL,
		SPR_ID_L2_STAT,
		SPR_ID_PROC_ID
	} spr_id_type;

	// Cache invalidate sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_XLATE,
		ST_INVAL,
		ST_BCAST
	} icbi_state_type;

endpackage

/* rtl/spr_map.sv */
// Special register number reassembly and implementation register lookup.
`timescale 1ns/1ps
module spr_map (
	// Instruction word
	input wire logic [31:0] i_instr,
	// Decoded register
	output logic [9:0] o_spr_num,
	output sysdec_pkg::spr_id_type o_spr_id,
	output logic [2:0] o_perf_idx,
	output logic o_spr_priv
);
	import sysdec_pkg::*;

	logic [9:0] num;
	logic [9:0] perf_off;

	// Swap the halves back into a plain number, and
	assign num = {i_instr[SPR_HALF_A_HI:SPR_HALF_A_LO], i_instr[SPR_HALF_B_HI:SPR_HALF_B_LO]};
	assign o_spr_num = num;
	// Supervisor registers have the number MSB set
	assign o_spr_priv = num[SPR_PRIV_BIT];
	// Counter index counted from the first counter
	assign perf_off = num - SPR_PERF_FIRST;

	// Table lookup of implementation registers
	always_comb begin
		o_spr_id = SPR_ARCH;
		o_perf_idx = 3'h0;
		if (num >= SPR_PERF_FIRST && num <= SPR_PERF_LAST) begin
			// Eight counters
			o_spr_id = SPR_ID_PERF;
			o_perf_idx = perf_off[2:0];
		end else begin
			unique case (num)
				SPR_MON_CTRL_0: o_spr_id = SPR_ID_MON_CTRL_0;
				SPR_MON_CTRL_1: o_spr_id = SPR_ID_MON_CTRL_1;
				SPR_SAMPLED_IA: o_spr_id = SPR_ID_SAMPLED_IA;
				SPR_SAMPLED_DA: o_spr_id = SPR_ID_SAMPLED_DA;
				SPR_HW_IMPL_0: o_spr_id = SPR_ID_HW_IMPL_0;
				SPR_IBRK: o_spr_id = SPR_ID_IBRK;
				SPR_BUS_CS: o_spr_id = SPR_ID_BUS_CS;
				SPR_L2_CTRL: o_spr_id = SPR_ID_L2_CTRL;
				SPR_L2_STAT: o_spr_id = SPR_ID_L2_STAT;
				SPR_PROC_ID: o_spr_id = SPR_ID_PROC_ID;
				// Anything else is an architected register
				default: o_spr_id = SPR_ARCH;
			endcase
		end
	end

endmodule

/* rtl/sysdec.sv */
// System linkage, processor control and cache invalidate decode unit.
`timescale 1ns/1ps
module sysdec #(
	parameter int EA_W = 64,
	parameter int PA_W = 64
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Instruction issue
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [31:0] i_instr,
	input wire logic [EA_W-1:0] i_ea,
	input wire logic i_user_mode,
	// Translation and protection check
	output logic o_xlate_req,
	output logic [EA_W-1:0] o_xlate_ea,
	input wire logic i_xlate_done,
	input wire logic i_xlate_fault,
	input wire logic [PA_W-1:0] i_xlate_pa,
	// Instruction cache invalidate
	output logic o_ic_inval,
	output logic [PA_W-1:0] o_ic_addr,
	// Data cache side (never touched here)
	output logic o_dc_touch,
	// System bus invalidate broadcast
	output logic o_bus_icbi_req,
	output logic [PA_W-1:0] o_bus_addr,
	input wire logic i_bus_ack,
	// Cache invalidate completion
	output logic o_icbi_done,
	output logic o_icbi_fault,
	// External control access
	output logic o_ext_req,
	output logic o_ext_write,
	output logic o_ext_inhibit,
	output logic o_ext_split,
	// Exceptions and linkage
	output logic o_syscall_excp,
	output logic o_priv_excp,
	output logic o_rfi,
	output logic o_rfi_dword,
	// Machine state moves
	output logic o_msr_write,
	output logic o_msr_dword,
	output logic o_msr_read,
	// Special register moves
	output logic o_spr_write,
	output logic o_spr_read,
	output logic [9:0] o_spr_num,
	output sysdec_pkg::spr_id_type o_spr_id,
	output logic [2:0] o_perf_idx
);
	import sysdec_pkg::*;

	// Parameter sanity, refused while elaborating
	if (EA_W < 32 || PA_W < 32) begin
		$error("sysdec: address widths below 32 bits are not served");
	end

	// ======================================================
	// Decode
	// ======================================================
	logic [5:0] primary; // Primary opcode
	logic [9:0] xo; // Extended opcode
	logic [9:0] map_num; // Reassembled register number
	spr_id_type map_id; // Looked-up register
	logic [2:0] map_perf; // Counter index
	logic map_priv; // Supervisor register
	logic is_sc, is_rfi, is_rfid, is_icbi, is_ext_in, is_ext_out;
	logic is_mtmsr, is_mtmsrd, is_mfmsr, is_mtspr, is_mfspr;
	logic needs_priv; // Instruction or register is supervisor only
	logic priv_fail; // User mode tried a supervisor operation
	logic accept; // Instruction taken this cycle

	assign primary = i_instr[PRIMARY_HI:PRIMARY_LO];
	assign xo = i_instr[XO_HI:XO_LO];

	// Register number lookup
	spr_map u_spr_map (
		.i_instr(i_instr),
		.o_spr_num(map_num),
		.o_spr_id(map_id),
		.o_perf_idx(map_perf),
		.o_spr_priv(map_priv)
	);

	// Opcode matches
	assign is_sc = (primary == OP_SYSCALL);
	assign is_rfi = (primary == OP_BRANCH_EXT) && (xo == XO_RFI);
	assign is_rfid = (primary == OP_BRANCH_EXT) && (xo == XO_RFID);
	assign is_icbi = (primary == OP_INT_EXT) && (xo == XO_ICACHE_INVAL);
	assign is_ext_in = (primary == OP_INT_EXT) && (xo == XO_EXT_IN);
	assign is_ext_out = (primary == OP_INT_EXT) && (xo == XO_EXT_OUT);
	assign is_mtmsr = (primary == OP_INT_EXT) && (xo == XO_MSR_TO);
	assign is_mtmsrd = (primary == OP_INT_EXT) && (xo == XO_MSR_TO_D);
	assign is_mfmsr = (primary == OP_INT_EXT) && (xo == XO_MSR_FROM);
	assign is_mtspr = (primary == OP_INT_EXT) && (xo == XO_SPR_TO);
	assign is_mfspr = (primary == OP_INT_EXT) && (xo == XO_SPR_FROM);

	// Supervisor-only work: returns, machine state, high registers
	assign needs_priv = is_rfi || is_rfid || is_mtmsr || is_mtmsrd || is_mfmsr
		|| ((is_mtspr || is_mfspr) && map_priv); // and
	assign priv_fail = needs_priv && i_user_mode;

	// ======================================================
	// Cache invalidate sequencer
	// ======================================================
	icbi_state_type state_q, state_d;
	logic [EA_W-1:0] ea_q; // Address under translation
	logic [PA_W-1:0] pa_q; // Translated address

	// Issue is held off while an invalidate is in flight
	assign o_ready = (state_q == ST_IDLE);
	assign accept = i_valid && o_ready;

	// Next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				// Translate first
				if (accept && is_icbi) begin
					state_d = ST_XLATE;
				end
			end
			ST_XLATE: begin
				if (i_xlate_done) begin
					// A protection fault ends the sequence with no cache action
					state_d = i_xlate_fault ? ST_IDLE : ST_INVAL;
				end
			end
			// One-cycle local invalidate, then broadcast regardless of hit
			ST_INVAL: state_d = ST_BCAST;
			ST_BCAST: begin
				if (i_bus_ack) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Address capture
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ea_q <= '0;
			pa_q <= '0;
		end else begin
			if (accept && is_icbi) begin
				ea_q <= i_ea;
			end
			if (state_q == ST_XLATE && i_xlate_done) begin
				pa_q <= i_xlate_pa;
			end
		end
	end

	// Translation request holds until the answer
	assign o_xlate_req = (state_q == ST_XLATE);
	assign o_xlate_ea = ea_q;
	// Cache drops the block if present
	assign o_ic_inval = (state_q == ST_INVAL);
	assign o_ic_addr = pa_q;
	// Data cache is left alone by this instruction
	assign o_dc_touch = 1'b0;
	// Bus broadcast holds until acknowledged
	assign o_bus_icbi_req = (state_q == ST_BCAST);
	assign o_bus_addr = pa_q;

	// Completion pulses
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_icbi_done <= 1'b0;
			o_icbi_fault <= 1'b0;
		end else begin
			o_icbi_done <= (state_q == ST_BCAST) && i_bus_ack;
			o_icbi_fault <= (state_q == ST_XLATE) && i_xlate_done && i_xlate_fault;
		end
	end

	// ======================================================
	// External control accesses
	// ======================================================
	// Misaligned word goes out inhibited and split
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ext_req <= 1'b0;
			o_ext_write <= 1'b0;
			o_ext_inhibit <= 1'b0;
			o_ext_split <= 1'b0;
		end else begin
			o_ext_req <= accept && (is_ext_in || is_ext_out);
			o_ext_write <= accept && is_ext_out;
			o_ext_inhibit <= accept && (is_ext_in || is_ext_out)
				&& ((i_ea[1:0] & WORD_ALIGN_MASK) != 2'h0);
			o_ext_split <= accept && (is_ext_in || is_ext_out)
				&& ((i_ea[1:0] & WORD_ALIGN_MASK) != 2'h0);
		end
	end

	// ======================================================
	// Linkage and exceptions
	// ======================================================
	// Exception and return pulses
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_syscall_excp <= 1'b0;
			o_priv_excp <= 1'b0;
			o_rfi <= 1'b0;
			o_rfi_dword <= 1'b0;
		end else begin
			// Allowed from user level
			o_syscall_excp <= accept && is_sc;
			// Refused supervisor work
			o_priv_excp <= accept && priv_fail;
			// Resume the interrupted program
			o_rfi <= accept && (is_rfi || is_rfid) && !i_user_mode;
			o_rfi_dword <= accept && is_rfid && !i_user_mode;
		end
	end

	// ======================================================
	// Machine state and special register moves
	// ======================================================
	// Machine state move pulses
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_msr_write <= 1'b0;
			o_msr_dword <= 1'b0;
			o_msr_read <= 1'b0;
		end else begin
			o_msr_write <= accept && (is_mtmsr || is_mtmsrd) && !i_user_mode;
			o_msr_dword <= accept && is_mtmsrd && !i_user_mode;
			o_msr_read <= accept && is_mfmsr && !i_user_mode;
		end
	end

	// Special register move pulses, blocked on a privilege fault
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_spr_write <= 1'b0;
			o_spr_read <= 1'b0;
		end else begin
			o_spr_write <= accept && is_mtspr && !priv_fail;
			o_spr_read <= accept && is_mfspr && !priv_fail;
		end
	end

	// Register selection held until the next move
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_spr_num <= 10'h000;
			o_spr_id <= SPR_ARCH;
			o_perf_idx <= 3'h0;
		end else if (accept && (is_mtspr || is_mfspr)) begin
			// Decoded number and target, and
			o_spr_num <= map_num;
			o_spr_id <= map_id;
			o_perf_idx <= map_perf;
		end
	end

endmodule

/* test/sysdec_properties.sv */
// Port-level checks for the system decode unit.
`timescale 1ns/1ps
module sysdec_checker import sysdec_pkg::*; #(
	parameter int EA_W = 64,
	parameter int PA_W = 64
) (
	// Clock, reset and issue
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire logic o_ready,
	input wire logic [31:0] i_instr,
	input wire logic [EA_W-1:0] i_ea,
	input wire logic i_user_mode,
	// Invalidate sequence
	input wire logic o_xlate_req,
	input wire logic i_xlate_done,
	input wire logic i_xlate_fault,
	input wire logic o_ic_inval,
	input wire logic [PA_W-1:0] o_ic_addr,
	input wire logic o_dc_touch,
	input wire logic o_bus_icbi_req,
	input wire logic [PA_W-1:0] o_bus_addr,
	input wire logic i_bus_ack,
	input wire logic o_icbi_done,
	input wire logic o_icbi_fault,
	// Decode results
	input wire logic o_ext_inhibit,
	input wire logic o_ext_split,
	input wire logic o_syscall_excp,
	input wire logic o_priv_excp,
	input wire logic o_rfi,
	input wire logic [9:0] o_spr_num
);
	// ==========================
	// Helpers
	// ==========================
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// Accepted issue slots by kind
	wire acc = i_valid && o_ready;
	wire is_x = acc && i_instr[31:26] == OP_INT_EXT;
	wire is_spr = is_x && (i_instr[10:1] == XO_SPR_TO || i_instr[10:1] == XO_SPR_FROM);
	wire is_ext = is_x && (i_instr[10:1] == XO_EXT_IN || i_instr[10:1] == XO_EXT_OUT);
	wire is_rfi = acc && i_instr[31:26] == OP_BRANCH_EXT && i_instr[10:1] == XO_RFI;
	// Translation answered clean or faulting
	sequence s_xlate_ok;
		o_xlate_req && i_xlate_done && !i_xlate_fault;
	endsequence
	sequence s_xlate_bad;
		o_xlate_req && i_xlate_done && i_xlate_fault;
	endsequence
	// Broadcast acknowledged
	sequence s_bcast_ack;
		o_bus_icbi_req && i_bus_ack;
	endsequence
	// ==========================
	// Assertions
	// ==========================
	a_inval_after_xlate: assert property (s_xlate_ok |=> o_ic_inval ##1 o_bus_icbi_req)
		else $error("invalidate did not follow clean translation");
	a_inval_needs_xlate: assert property ($rose(o_ic_inval)
		|-> $past(o_xlate_req && i_xlate_done && !i_xlate_fault))
		else $error("invalidate without clean translation");
	a_fault_no_action: assert property (s_xlate_bad
		|=> o_icbi_fault && !o_ic_inval ##1 !o_bus_icbi_req)
		else $error("faulting invalidate acted");
	a_bcast_always: assert property (o_ic_inval
		|=> o_bus_icbi_req && o_bus_addr == $past(o_ic_addr))
		else $error("invalidate not broadcast");
	a_ack_completes: assert property (s_bcast_ack
		|=> o_icbi_done && !o_bus_icbi_req && o_ready)
		else $error("broadcast ack did not complete");
	a_dcache_quiet: assert property (!o_dc_touch)
		else $error("data cache touched");
	a_spr_halves: assert property (is_spr
		|=> o_spr_num == {$past(i_instr[15:11]), $past(i_instr[20:16])})
		else $error("register number halves wrong");
	a_ext_misalign: assert property (is_ext |=> o_ext_inhibit == ($past(i_ea[1:0]) != 2'h0)
		&& o_ext_split == o_ext_inhibit)
		else $error("misaligned external access handling wrong");
	a_syscall_trap: assert property (acc && i_instr[31:26] == OP_SYSCALL
		|=> o_syscall_excp)
		else $error("system call without exception");
	a_user_rfi_refused: assert property (is_rfi && i_user_mode |=> o_priv_excp && !o_rfi)
		else $error("user interrupt return not refused");
	a_super_rfi_runs: assert property (is_rfi && !i_user_mode |=> o_rfi && !o_priv_excp)
		else $error("supervisor interrupt return refused");
endmodule

bind sysdec sysdec_checker #(.EA_W(EA_W), .PA_W(PA_W)) chk_u (.i_mclk, .i_rst_n, .i_valid,
	.o_ready, .i_instr, .i_ea, .i_user_mode, .o_xlate_req, .i_xlate_done, .i_xlate_fault,
	.o_ic_inval, .o_ic_addr, .o_dc_touch, .o_bus_icbi_req, .o_bus_addr, .i_bus_ack,
	.o_icbi_done, .o_icbi_fault, .o_ext_inhibit, .o_ext_split, .o_syscall_excp,
	.o_priv_excp, .o_rfi, .o_spr_num);

/* test/far_side_model.sv */
// Translation unit and bus participant answering the decode unit.
`timescale 1ns/1ps
module far_side_model #(
	parameter int EA_W = 64,
	parameter int PA_W = 64,
	parameter logic [63:0] PA_OFS = 64'h0000_0001_0000_0000
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Translation side
	input wire logic i_xlate_req,
	input wire logic [EA_W-1:0] i_xlate_ea,
	input wire logic [3:0] i_xlate_dly,
	input wire logic i_fault_cmd,
	output logic o_xlate_done,
	output logic o_xlate_fault,
	output logic [PA_W-1:0] o_xlate_pa,
	// Bus side
	input wire logic i_bus_req,
	input wire logic [3:0] i_ack_dly,
	output logic o_bus_ack
);
	logic [3:0] xl_cnt_q; // Translation wait count
	logic [3:0] ack_cnt_q; // Bus wait count
	// ==========================
	// Translation answer
	// ==========================
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			xl_cnt_q <= 4'h0;
			o_xlate_done <= 1'b0;
			o_xlate_fault <= 1'b0;
			o_xlate_pa <= '0;
		end else if (o_xlate_done) begin
			// Answer stands one cycle, then qualifiers turn stale
			o_xlate_done <= 1'b0;
			xl_cnt_q <= 4'h0;
			o_xlate_fault <= ~o_xlate_fault;
			o_xlate_pa <= ~o_xlate_pa;
		end else if (i_xlate_req && xl_cnt_q == i_xlate_dly) begin
			o_xlate_done <= 1'b1;
			o_xlate_fault <= i_fault_cmd;
			o_xlate_pa <= PA_W'(i_xlate_ea) + PA_W'(PA_OFS);
		end else if (i_xlate_req) begin
			xl_cnt_q <= xl_cnt_q + 4'h1;
		end
	end
	// ==========================
	// Bus acknowledge
	// ==========================
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_cnt_q <= 4'h0;
			o_bus_ack <= 1'b0;
		end else if (o_bus_ack) begin
			o_bus_ack <= 1'b0;
			ack_cnt_q <= 4'h0;
		end else if (i_bus_req && ack_cnt_q == i_ack_dly) begin
			o_bus_ack <= 1'b1;
		end else if (i_bus_req) begin
			ack_cnt_q <= ack_cnt_q + 4'h1;
		end
	end
endmodule

/* test/tb.sv */
// Self-checking testbench for the system decode unit.
`timescale 1ns/1ps
module tb;
	import sysdec_pkg::*;
	localparam logic [63:0] OFS = 64'h0000_0001_0000_0000;
	localparam logic [12:0] ALL = 13'h1FFF;
	// Design ports
	logic i_mclk = 1'b0, i_rst_n = 1'b0, i_valid = 1'b0, i_user_mode = 1'b0;
	logic [31:0] i_instr = 32'h0;
	logic [63:0] i_ea = 64'h0, o_xlate_ea, i_xlate_pa, o_ic_addr, o_bus_addr;
	logic o_ready, o_xlate_req, i_xlate_done, i_xlate_fault, o_ic_inval, o_dc_touch;
	logic o_bus_icbi_req, i_bus_ack, o_icbi_done, o_icbi_fault, o_ext_req, o_ext_write;
	logic o_ext_inhibit, o_ext_split, o_syscall_excp, o_priv_excp, o_rfi, o_rfi_dword;
	logic o_msr_write, o_msr_dword, o_msr_read, o_spr_write, o_spr_read;
	logic [9:0] o_spr_num;
	spr_id_type o_spr_id;
	logic [2:0] o_perf_idx;
	// Partner commands
	logic [3:0] xl_dly = 4'h0, ack_dly = 4'h0;
	logic flt_cmd = 1'b0;
	// Bookkeeping
	int mismatches = 0, n_compared = 0, ninval = 0, nbcast = 0, ndc = 0;
	// All one-cycle decode pulses in one vector
	wire [12:0] dec = {o_syscall_excp, o_priv_excp, o_rfi, o_rfi_dword, o_msr_write,
		o_msr_dword, o_msr_read, o_spr_write, o_spr_read, o_ext_req, o_ext_write,
		o_ext_inhibit, o_ext_split};

	sysdec dut_u (.i_mclk, .i_rst_n, .i_valid, .o_ready, .i_instr, .i_ea, .i_user_mode,
		.o_xlate_req, .o_xlate_ea, .i_xlate_done, .i_xlate_fault, .i_xlate_pa, .o_ic_inval,
		.o_ic_addr, .o_dc_touch, .o_bus_icbi_req, .o_bus_addr, .i_bus_ack, .o_icbi_done,
		.o_icbi_fault, .o_ext_req, .o_ext_write, .o_ext_inhibit, .o_ext_split,
		.o_syscall_excp, .o_priv_excp, .o_rfi, .o_rfi_dword, .o_msr_write, .o_msr_dword,
		.o_msr_read, .o_spr_write, .o_spr_read, .o_spr_num, .o_spr_id, .o_perf_idx);

	far_side_model #(.PA_OFS(OFS)) far_u (.i_mclk, .i_rst_n, .i_xlate_req(o_xlate_req),
		.i_xlate_ea(o_xlate_ea), .i_xlate_dly(xl_dly), .i_fault_cmd(flt_cmd),
		.o_xlate_done(i_xlate_done), .o_xlate_fault(i_xlate_fault), .o_xlate_pa(i_xlate_pa),
		.i_bus_req(o_bus_icbi_req), .i_ack_dly(ack_dly), .o_bus_ack(i_bus_ack));

	// ==========================
	// Clock and monitors
	// ==========================
	always #2 i_mclk = ~i_mclk;
	// Count invalidates, acknowledged broadcasts, data cache touches
	always @(posedge i_mclk) begin
		if (o_ic_inval === 1'b1) ninval++;
		if (o_bus_icbi_req === 1'b1 && i_bus_ack === 1'b1) nbcast++;
		if (o_dc_touch !== 1'b0) ndc++;
	end

	// ==========================
	// Shared tasks
	// ==========================
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic summarize();
		$display("TB: compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Indexed-form word with register number split into swapped halves
	function automatic logic [31:0] xf(input logic [9:0] xo, input logic [9:0] num);
		return {OP_INT_EXT, 5'h03, num[4:0], num[9:5], xo, 1'b0};
	endfunction

	// Offer one instruction; returns in the answer cycle
	task automatic issue(input logic [31:0] ins, input logic [63:0] ea, input logic usr);
		@(posedge i_mclk);
		#1;
		i_instr = ins;
		i_ea = ea;
		i_user_mode = usr;
		i_valid = 1'b1;
		@(posedge i_mclk);
		#1;
		i_valid = 1'b0;
	endtask

	// Issue and judge the masked decode pulses
	task automatic op(input logic [31:0] ins, input logic [63:0] ea, input logic usr,
		input logic [12:0] exp, input logic [12:0] care);
		issue(ins, ea, usr);
		chk(64'(dec & care), 64'(exp), "decode pulses");
	endtask

	// ==========================
	// Scenarios
	// ==========================
	// Linkage and machine state moves, then the same in user mode
	task automatic t_linkage();
		logic [31:0] pl [5] = '{{OP_BRANCH_EXT, 15'h0, XO_RFI, 1'b0},
			{OP_BRANCH_EXT, 15'h0, XO_RFID, 1'b0}, xf(XO_MSR_TO, 10'h0),
			xf(XO_MSR_TO_D, 10'h0), xf(XO_MSR_FROM, 10'h0)};
		op({OP_SYSCALL, 26'h2}, 64'h0, 1'b1, 13'h1000, ALL);
		op(pl[0], 64'h0, 1'b0, 13'h0400, ALL);
		op(pl[1], 64'h0, 1'b0, 13'h0600, ALL);
		op(pl[2], 64'h0, 1'b0, 13'h0100, ALL);
		op(pl[3], 64'h0, 1'b0, 13'h0180, ALL);
		op(pl[4], 64'h0, 1'b0, 13'h0040, ALL);
		foreach (pl[i]) op(pl[i], 64'h0, 1'b1, 13'h0800, ALL);
		op(xf(XO_SPR_TO, 10'h3F0), 64'h0, 1'b1, 13'h0800, ALL);
		op(xf(XO_SPR_FROM, 10'h008), 64'h0, 1'b1, 13'h0010, ALL);
	endtask

	// External control: aligned, misaligned, both directions
	task automatic t_ext();
		op(xf(XO_EXT_IN, 10'h0), 64'h100, 1'b0, 13'h0008, ALL);
		op(xf(XO_EXT_IN, 10'h0), 64'h102, 1'b0, 13'h000B, ALL);
		op(xf(XO_EXT_OUT, 10'h0), 64'h104, 1'b1, 13'h000C, ALL);
		op(xf(XO_EXT_OUT, 10'h0), 64'h107, 1'b1, 13'h000F, ALL);
	endtask

	// Every implementation register, counters at 787, 790 and 794 only, plus architected 8, alternating move directions
	task automatic t_spr_map();
		int nums [14] = '{795, 798, 787, 790, 794, 780, 781, 1008, 1010, 1016, 1017, 1018,
			1023, 8};
		spr_id_type ids [14] = '{SPR_ID_MON_CTRL_0, SPR_ID_MON_CTRL_1, SPR_ID_PERF,
			SPR_ID_PERF, SPR_ID_PERF, SPR_ID_SAMPLED_IA, SPR_ID_SAMPLED_DA, SPR_ID_HW_IMPL_0,
			SPR_ID_IBRK, SPR_ID_BUS_CS, SPR_ID_L2_CTRL, SPR_ID_L2_STAT, SPR_ID_PROC_ID,
			SPR_ARCH};
		foreach (nums[i]) begin
			op(xf(i % 2 ? XO_SPR_TO : XO_SPR_FROM, 10'(nums[i])), 64'h0, 1'b0,
				i % 2 ? 13'h0020 : 13'h0010, ALL);
			chk(64'(o_spr_num), 64'(nums[i]), "register number");
			chk(64'(o_spr_id), 64'(ids[i]), "register select"); // and
			if (ids[i] == SPR_ID_PERF) begin
				chk(64'(o_perf_idx), 64'(nums[i] - 787), "counter");
			end
		end
	endtask

	// One invalidate with the given partner pacing and fault command
	task automatic t_icbi(input logic [63:0] ea, input logic [3:0] xd, input logic [3:0] ad,
		input logic flt, input logic usr);
		int n;
		ninval = 0;
		nbcast = 0;
		xl_dly = xd;
		ack_dly = ad;
		flt_cmd = flt;
		issue(xf(XO_ICACHE_INVAL, 10'h0), ea, usr);
		chk(64'(o_ready), 64'h0, "busy while translating");
		for (n = 0; n < 60 && o_icbi_done !== 1'b1 && o_icbi_fault !== 1'b1; n++) begin
			@(posedge i_mclk);
			#1;
		end
		if (n == 60) begin
			mismatches++;
			summarize();
		end
		chk(64'(o_icbi_fault), 64'(flt), "fault completion");
		chk(64'(o_ready), 64'h1, "ready after invalidate");
		chk(o_xlate_ea, ea, "translated address");
		chk(64'(ninval), flt ? 64'h0 : 64'h1, "invalidate count");
		chk(64'(nbcast), flt ? 64'h0 : 64'h1, "broadcast count");
		if (!flt) chk(o_bus_addr, ea + OFS, "broadcast address");
		if (!flt) chk(o_ic_addr, ea + OFS, "invalidate address");
		chk(64'(ndc), 64'h0, "data cache untouched");
	endtask

	// ==========================
	// Main sequence
	// ==========================
	initial begin
		repeat (4) @(posedge i_mclk);
		#1;
		i_rst_n = 1'b1;
		t_linkage();
		t_ext();
		t_spr_map();
		t_icbi(64'h1000, 4'h0, 4'h0, 1'b0, 1'b0);
		t_icbi(64'h2A40, 4'h3, 4'h5, 1'b0, 1'b1);
		t_icbi(64'h3000, 4'h1, 4'h0, 1'b1, 1'b0);
		t_icbi(64'h4080, 4'h2, 4'h1, 1'b0, 1'b0);
		summarize();
	end
endmodule
